// ===== design/scfg_pkg.sv
// Package of constants and carrier types for the sensor configuration slave.
package scfg_pkg;

    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [7:0] IDX_PART_MIRROR = 8'h01; // Mirror of identifier.
    localparam logic [7:0] IDX_STATUS = 8'h02; // Fault code and ready.
    localparam logic [7:0] IDX_PART_IDENTIFIER_FUSE = 8'hA4; // Part identifier fuse.
    localparam logic [7:0] IDX_SYS_CFG = 8'hA5; // System configuration.
    localparam logic [7:0] IDX_P_CFG = 8'hA6; // Pressure oversampling.
    localparam logic [7:0] IDX_T_CFG = 8'hA7; // Temperature oversampling.

    // ****************************************
    // Fields and address
    // ****************************************
    localparam int DIAG_BIT = 0; // Diagnosis enable position.
    localparam int OSR_W = 3; // Width of a ratio field.
    localparam int FAULT_LSB = 4; // Fault code sits in bits 7..4.
    localparam logic [5:0] ADDR_HIGH = 6'h36; // Upper six bits 110110.
    localparam logic [3:0] BIT_COUNT_LAST = 4'h7; // Last bit index.

    // ****************************************
    // Carrier types
    // ****************************************
    // Fuse image presented at power-up.
    typedef struct packed {
        logic [7:0] part_identifier;
        logic [7:0] sys_cfg;
        logic [7:0] p_cfg;
        logic [7:0] t_cfg;
    } scfg_regs_s;

    // Byte engine states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_WBYTE = 3'h2,
        ST_WACK = 3'h6,
        ST_RBYTE = 3'h7,
        ST_RACK = 3'h5
    } scfg_state_e;

endpackage : scfg_pkg

// ===== design/scfg_sync.sv
// Two-flop synchroniser with edge detection for the bus pins.
`timescale 1ns/1ns
module scfg_sync #(
    parameter int W = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);
    // All state of the synchroniser: two capture stages and a history.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } scfg_sync_s;

    scfg_sync_s st_q; // Registered state.
    scfg_sync_s st_d; // Next state.

    // Shift the pins along; the bus idles high, so reset to ones.
    always_comb begin
        st_d = st_q;
        st_d.s1 = i_async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // Register the stages; only the second and third stages feed logic.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    // Edges compare the second and third stages only.
    assign o_level = st_q.s2;
    assign o_rise = st_q.s2 & ~st_q.s3;
    assign o_fall = ~st_q.s2 & st_q.s3;
endmodule : scfg_sync

// ===== design/scfg_i2c_slave.sv
// I2C slave that holds the sensor's fuse-backed configuration registers.
`timescale 1ns/1ns
module scfg_i2c_slave (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_address_select_pin,
    input wire scfg_pkg::scfg_regs_s i_fuse,
    input wire logic [3:0] i_fault_detect,
    input wire logic i_data_ready,
    output logic o_diag_enable,
    output logic [2:0] o_pressure_oversampling,
    output logic [2:0] o_temperature_oversampling,
    output logic o_busy
);

    // ****************************************
    // State
    // ****************************************
    // All module state in one record.
    typedef struct packed {
        scfg_pkg::scfg_state_e state;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic is_read;
        logic have_index;
        logic [7:0] index;
        logic drive_low;
        logic loaded;
        scfg_pkg::scfg_regs_s regs;
        logic [3:0] fault;
    } scfg_top_s;

    scfg_top_s st_q; // Registered state.
    scfg_top_s st_d; // Next state.

    logic scl_lvl; // Synchronised clock level.
    logic sda_lvl; // Synchronised data level.
    logic pin_lvl; // Synchronised address strap level.
    logic [2:0] rise; // Rising edges, bit 2 strap, bit 1 clock, bit 0 data.
    logic [2:0] fall; // Falling edges, bit 2 strap, bit 1 clock, bit 0 data.
    logic [7:0] rd_val; // Byte that a read of the current index returns.
    logic start_det; // Start or repeated start seen.
    logic stop_det; // Stop seen.
    logic [6:0] my_addr; // Address this device answers.

    // ****************************************
    // Pin synchroniser
    // ****************************************
    // Pins cross from the bus domain through two flops.
    scfg_sync #(
        .W(3)
    ) u_sync (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_async({i_address_select_pin, i_scl, i_sda}),
        .o_level({pin_lvl, scl_lvl, sda_lvl}),
        .o_rise(rise),
        .o_fall(fall)
    );

    // Data changing while the clock is high frames a transfer.
    assign start_det = scl_lvl & fall[0];
    assign stop_det = scl_lvl & rise[0];
    // The strap is read through the synchroniser; it shows one for two
    // cycles after reset, which is harmless as no transfer starts so soon.
    assign my_addr = {scfg_pkg::ADDR_HIGH, pin_lvl};

    // Read decode, used for the first byte and every following byte.
    function automatic logic [7:0] read_reg(input scfg_top_s s);
        logic [7:0] v;
        v = 8'h00;
        unique case (s.index)
            scfg_pkg::IDX_PART_MIRROR: v = s.regs.part_identifier;
            scfg_pkg::IDX_STATUS: v = {s.fault, 2'h0, 1'b0,
                                       i_data_ready};
            scfg_pkg::IDX_PART_IDENTIFIER_FUSE: v = s.regs.part_identifier;
            scfg_pkg::IDX_SYS_CFG: v = s.regs.sys_cfg;
            scfg_pkg::IDX_P_CFG: v = s.regs.p_cfg;
            scfg_pkg::IDX_T_CFG: v = s.regs.t_cfg;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    // One decode serves every place that loads a read byte.
    assign rd_val = read_reg(st_q);

    // ****************************************
    // Next state
    // ****************************************
    // The engine samples data on clock rise and changes it on clock fall,
    // so the slave never moves data while the master's clock is high.
    always_comb begin
        st_d = st_q;
        // Fuse image copied in once, in the first cycle after reset.
        if (!st_q.loaded) begin
            st_d.regs = i_fuse;
            st_d.loaded = 1'b1;
        end
        // Faults collect only while diagnosis is on; new faults are ORed into the held code.
        if (st_q.regs.sys_cfg[scfg_pkg::DIAG_BIT]) begin
            st_d.fault = st_q.fault | i_fault_detect;
        end else begin
            st_d.fault = 4'h0;
        end
        if (stop_det) begin
            // Stop ends any transfer and frees the data line.
            st_d.state = scfg_pkg::ST_IDLE;
            st_d.drive_low = 1'b0;
        end else if (start_det) begin
            st_d.state = scfg_pkg::ST_ADDR;
            st_d.bitcnt = 4'h0;
            st_d.drive_low = 1'b0;
            st_d.have_index = 1'b0;
        end else begin
            unique case (st_q.state)
                scfg_pkg::ST_IDLE: begin
                    st_d.drive_low = 1'b0;
                end
                scfg_pkg::ST_ADDR, scfg_pkg::ST_WBYTE: begin
                    // Shift in most significant bit first.
                    if (rise[1]) begin
                        st_d.shift = {st_q.shift[6:0], sda_lvl};
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end
                    if (fall[1] &&
                        st_q.bitcnt == scfg_pkg::BIT_COUNT_LAST + 4'h1) begin
                        st_d.bitcnt = 4'h0;
                        if (st_q.state == scfg_pkg::ST_ADDR) begin
                            if (st_q.shift[7:1] == my_addr) begin
                                st_d.is_read = st_q.shift[0];
                                st_d.drive_low = 1'b1;
                                st_d.state = scfg_pkg::ST_AACK;
                            end else begin
                                // Other address: stay silent until the next start or repeated start.
                                st_d.state = scfg_pkg::ST_IDLE;
                            end
                        end else begin
                            // First byte is the index, later bytes data.
                            if (!st_q.have_index) begin
                                st_d.index = st_q.shift;
                                st_d.have_index = 1'b1;
                            end else begin
                                unique case (st_q.index)
                                    scfg_pkg::IDX_PART_IDENTIFIER_FUSE:
                                        st_d.regs.part_identifier =
                                            st_q.shift;
                                    scfg_pkg::IDX_SYS_CFG:
                                        st_d.regs.sys_cfg = st_q.shift;
                                    scfg_pkg::IDX_P_CFG:
                                        st_d.regs.p_cfg[2:0] =
                                            st_q.shift[2:0];
                                    scfg_pkg::IDX_T_CFG:
                                        st_d.regs.t_cfg[2:0] =
                                            st_q.shift[2:0];
                                    default: ;
                                endcase
                                st_d.index = st_q.index + 8'h01;
                            end
                            st_d.drive_low = 1'b1;
                            st_d.state = scfg_pkg::ST_WACK;
                        end
                    end
                end
                scfg_pkg::ST_AACK, scfg_pkg::ST_WACK: begin
                    // Acknowledge bit ends on the next clock fall.
                    if (fall[1] && st_q.bitcnt == 4'h1) begin
                        st_d.bitcnt = 4'h0;
                        if (st_q.state == scfg_pkg::ST_AACK &&
                            st_q.is_read) begin
                            st_d.shift = rd_val;
                            st_d.drive_low = ~rd_val[7];
                            st_d.state = scfg_pkg::ST_RBYTE;
                        end else begin
                            st_d.drive_low = 1'b0;
                            st_d.state = scfg_pkg::ST_WBYTE;
                        end
                    end else if (rise[1]) begin
                        st_d.bitcnt = 4'h1;
                    end
                end
                scfg_pkg::ST_RBYTE: begin
                    if (rise[1]) begin
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end
                    if (fall[1]) begin
                        if (st_q.bitcnt ==
                            scfg_pkg::BIT_COUNT_LAST + 4'h1) begin
                            st_d.drive_low = 1'b0;
                            st_d.bitcnt = 4'h0;
                            st_d.index = st_q.index + 8'h01;
                            st_d.state = scfg_pkg::ST_RACK;
                        end else begin
                            st_d.shift = {st_q.shift[6:0], 1'b0};
                            st_d.drive_low = ~st_q.shift[6];
                        end
                    end
                end
                scfg_pkg::ST_RACK: begin
                    // Master acknowledge continues; no acknowledge ends.
                    if (rise[1]) begin
                        st_d.is_read = ~sda_lvl;
                        st_d.bitcnt = 4'h1;
                    end
                    if (fall[1] && st_q.bitcnt == 4'h1) begin
                        st_d.bitcnt = 4'h0;
                        if (st_q.is_read) begin
                            st_d.shift = rd_val;
                            st_d.drive_low = ~rd_val[7];
                            st_d.state = scfg_pkg::ST_RBYTE;
                        end else begin
                            st_d.state = scfg_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_d.state = scfg_pkg::ST_IDLE;
                    st_d.drive_low = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Synchronous reset; the fuse image loads in the first cycle after.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Open-drain data: only ever pull low.
    assign o_sda = 1'b0;
    assign o_sda_oe = st_q.drive_low;
    assign o_diag_enable = st_q.regs.sys_cfg[scfg_pkg::DIAG_BIT];
    assign o_pressure_oversampling =
        st_q.regs.p_cfg[scfg_pkg::OSR_W-1:0];
    assign o_temperature_oversampling =
        st_q.regs.t_cfg[scfg_pkg::OSR_W-1:0];
    assign o_busy = (st_q.state != scfg_pkg::ST_IDLE);
endmodule : scfg_i2c_slave

// ===== testbench/scfg_i2c_master.sv
// Behavioural bus master that drives the clock and the open-drain data line.
`timescale 1ns/1ns
module scfg_i2c_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // The bus idles released, with the clock high.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // Data moves only while the clock is low, so no false start or stop.
    task automatic bit_io(input logic b, output logic r);
        o_sda_low <= !b;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        r = i_sda;
        o_scl <= 1'b0;
        tick(2);
    endtask : bit_io
    // Start, or repeated start when the clock is low.
    task automatic start();
        o_sda_low <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_low <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
        tick(2);
    endtask : start
    // Stop leaves the bus idle.
    task automatic stop();
        o_sda_low <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_low <= 1'b0;
        tick(4);
    endtask : stop
    // Eight bits, most significant first, then the acknowledge bit.
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, ack);
    endtask : wr_byte
    task automatic rd_byte(output logic [7:0] d, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, r);
    endtask : rd_byte
endmodule : scfg_i2c_master

// ===== testbench/scfg_i2c_slave_checker.sv
// Port assertions for the sensor configuration slave.
`timescale 1ns/1ns
module scfg_i2c_slave_checker (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_oe,
    input wire scfg_pkg::scfg_regs_s i_fuse,
    input wire logic o_diag_enable,
    input wire logic [2:0] o_pressure_oversampling,
    input wire logic [2:0] o_temperature_oversampling,
    input wire logic o_busy
);
    logic [1:0] settle_q; // Cycles since reset, saturating at three.
    // Masks the fuse load, which changes outputs while idle.
    always_ff @(posedge I_CORE_CLK) begin
        settle_q <= I_RST ? 2'h0 : settle_q + {1'b0, settle_q != 2'h3};
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    AST_FUSE_LOAD: assert property ($fell(I_RST) |-> ##2
        (o_pressure_oversampling == i_fuse.p_cfg[2:0] &&
        o_temperature_oversampling == i_fuse.t_cfg[2:0] &&
        o_diag_enable == i_fuse.sys_cfg[0]))
        else $error("outputs differ from fuse image");
    AST_OE_CLK_LOW: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data driver moved with clock high");
    AST_OE_HOLD: assert property (($rose(i_scl) && o_sda_oe) |->
        o_sda_oe[*4]) else $error("driven bit dropped early");
    AST_START_BUSY: assert property ((i_scl && $fell(i_sda)) |->
        ##[1:6] o_busy) else $error("start not taken");
    AST_STOP_IDLE: assert property ((i_scl && $rose(i_sda)) |->
        ##[1:6] !o_busy) else $error("stop not taken");
    AST_P_STABLE: assert property ((settle_q == 2'h3 &&
        $changed(o_pressure_oversampling)) |-> o_busy)
        else $error("pressure code moved while idle");
    AST_T_STABLE: assert property ((settle_q == 2'h3 &&
        $changed(o_temperature_oversampling)) |-> o_busy)
        else $error("temperature code moved while idle");
    AST_DIAG_STABLE: assert property ((settle_q == 2'h3 &&
        $changed(o_diag_enable)) |-> o_busy)
        else $error("diagnosis enable moved while idle");
endmodule : scfg_i2c_slave_checker
bind scfg_i2c_slave scfg_i2c_slave_checker u_scfg_i2c_slave_checker (
    .I_CORE_CLK, .I_RST, .i_scl, .i_sda, .o_sda_oe, .i_fuse, .o_diag_enable,
    .o_pressure_oversampling, .o_temperature_oversampling, .o_busy);

// ===== testbench/sensor_config_i2c_slave_test.sv
// Self-checking bench for the sensor configuration slave.
`timescale 1ns/1ns
module sensor_config_i2c_slave_test;
    localparam scfg_pkg::scfg_regs_s FUSE = {8'h5C, 8'h00, 8'hA8, 8'h73};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pin = 1'b1; // Address strap.
    logic [3:0] fault = 4'h0;
    logic ready = 1'b1;
    logic scl, m_low, oe, sda_o, diag, busy, ack;
    logic [2:0] posr, tosr, code;
    logic [4:0] up;
    logic [7:0] rd;
    wire sda = !(m_low || (oe && !sda_o)); // Pull-up when released.
    int fail_count = 0;
    int n_checks = 0;
    scfg_i2c_slave u_scfg_i2c_slave (.I_CORE_CLK(clk), .I_RST(rst),
        .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(oe),
        .i_address_select_pin(pin), .i_fuse(FUSE), .i_fault_detect(fault),
        .i_data_ready(ready), .o_diag_enable(diag), .o_busy(busy),
        .o_pressure_oversampling(posr), .o_temperature_oversampling(tosr));
    scfg_i2c_master u_scfg_i2c_master (.i_clk(clk), .i_sda(sda),
        .o_scl(scl), .o_sda_low(m_low));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // A byte that the slave must acknowledge with a low bit.
    task automatic send(input logic [7:0] b, input string what);
        u_scfg_i2c_master.wr_byte(b, ack);
        check(what, 8'h00, {7'h00, ack});
    endtask : send
    task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
        u_scfg_i2c_master.start();
        send({6'h36, pin, 1'b0}, "write address");
        send(idx, "index");
        send(d, "data");
        u_scfg_i2c_master.stop();
    endtask : write_reg
    // Index write, repeated start, one byte read and closed with a NACK.
    task automatic read_chk(input logic [7:0] idx, input logic [7:0] exp,
        input string what);
        u_scfg_i2c_master.start();
        send({6'h36, pin, 1'b0}, "write address");
        send(idx, "index");
        u_scfg_i2c_master.start();
        send({6'h36, pin, 1'b1}, "read address");
        u_scfg_i2c_master.rd_byte(rd, 1'b1);
        u_scfg_i2c_master.stop();
        check(what, exp, rd);
    endtask : read_chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // The whole sequence needs about 11700 cycles.
    initial begin
        #1600000;
        fail_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("diag out", 8'h00, {7'h00, diag});
        check("p out", {5'h00, FUSE.p_cfg[2:0]}, {5'h00, posr});
        read_chk(8'hA4, FUSE.part_identifier, "part_identifier_fuse");
        read_chk(8'h01, FUSE.part_identifier, "part mirror");
        write_reg(8'h01, 8'h00);
        read_chk(8'hA4, FUSE.part_identifier, "part kept");
        // Every code on both channels, upper bits written inverted.
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 8; i++) begin
                up = c ? FUSE.t_cfg[7:3] : FUSE.p_cfg[7:3];
                write_reg(8'hA6 + c[7:0], {~up, i[2:0]});
                code = c ? tosr : posr;
                check("code", 8'(i[2:0]), 8'(code));
                read_chk(8'hA6 + c[7:0], {up, i[2:0]}, "osr reg");
            end
        end
        write_reg(8'hA5, 8'h01);
        check("diag on", 8'h01, {7'h00, diag});
        @(posedge clk);
        fault <= 4'hA;
        read_chk(8'h02, 8'hA1, "status");
        @(posedge clk);
        fault <= 4'h0;
        // Drop data ready too, so the status bit 0 is seen to follow it.
        ready <= 1'b0;
        write_reg(8'hA5, 8'h00);
        check("diag off", 8'h00, {7'h00, diag});
        read_chk(8'h02, 8'h00, "status clear");
        u_scfg_i2c_master.start();
        u_scfg_i2c_master.wr_byte({6'h36, !pin, 1'b0}, ack);
        check("foreign address", 8'h01, {7'h00, ack});
        u_scfg_i2c_master.stop();
        // Second reset with the strap low.
        @(posedge clk);
        rst <= 1'b1;
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        read_chk(8'hA6, FUSE.p_cfg, "fuse reload");
        summarize();
    end
endmodule : sensor_config_i2c_slave_test
